//--- src/dfc_ctrl.sv
// controller end: AHB-Lite registers, clock divider and frequency change sequencer
//
// Function
// RULE1 - change clock only in self-refresh or power-down
// RULE2 - clock period fixed while in normal operation
// RULE3 - wait tCKSRE, new clock stable tCKSRX
// RULE4 - self-refresh entry and exit timings still apply
// RULE5 - new rate within speed grade limits
// RULE6 - power-down route same for fast/slow exit
// RULE7 - ODT held low if nominal termination enabled
// RULE8 - termination off if disabled, ODT free
// RULE9 - wait tCKSRE after CKE low before change
// RULE10 - ODT and CKE low during change
// RULE11 - stable new clock tCKSRX before exit
// RULE12 - after tXP, reset DLL via mode register
// RULE13 - optional mode register updates, CKE high
// RULE14 - ODT low, CKE high during relock
// RULE15 - device normal after DLL lock time
// RULE16 - termination off, outputs hi-z before change
// RULE17 - wait tDLLK before locked-DLL commands
// RULE18 - state machine with programmable timing counters
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dfc_defs.svh"
module dfc_ctrl #(
  parameter logic [7:0] DIV_MIN = `DFC_DIV_MIN,
  parameter logic [7:0] DIV_MAX = `DFC_DIV_MAX
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  dfc_link_if.ctrl         link
);
  typedef enum logic [3:0] {
    CS_IDLE, CS_ODT_OFF, CS_ENTER, CS_CHANGE, CS_EXIT, CS_DLL_RST, CS_MR_UPD, CS_RELOCK
  } dfc_cs_type;

  dfc_cs_type           st_reg, st_next;
  logic [15:0]          cnt_reg, cnt_next;
  logic [7:0]           div_reg, div_next, div_cnt_reg, new_div_reg;
  logic                 cke_next, odt_next, done_next;
  dfc_pkg::dfc_cmd_type cmd_next;
  logic                 route_pd_reg, upd_mr_reg, rtt_nom_reg, odt_idle_reg;
  logic                 start_reg, done_reg, range_err_reg;
  logic [15:0]          t_cksre_reg, t_cksrx_reg, t_xp_reg, t_mod_reg, t_dllk_reg, t_aof_reg;
  logic                 wr_pend_reg;
  logic [11:0]          wr_addr_reg;
  logic [1:0]           chg_tick_reg;

  // bus decode
  wire        addr_ph  = hsel_i & hready_i & htrans_i[1];
  wire        wr_now   = wr_pend_reg;
  wire        wr_ctrl  = wr_now & (wr_addr_reg == `DFC_OFS_CTRL);
  wire        wr_stat  = wr_now & (wr_addr_reg == `DFC_OFS_STATUS);
  wire        busy     = (st_reg != CS_IDLE);
  wire        in_range = (new_div_reg >= DIV_MIN) & (new_div_reg <= DIV_MAX); // RULE5
  wire        go       = start_reg & ~busy & in_range;
  wire        cnt_done = (cnt_reg == 16'h0000);
  wire [7:0]  wdiv     = hwdata_i[`DFC_CTRL_DIV_LSB +: 8];

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    unique case (a)
      `DFC_OFS_CTRL:   rd_mux = {16'h0000, new_div_reg, 3'h0, odt_idle_reg, rtt_nom_reg,
                                 upd_mr_reg, route_pd_reg, 1'b0};
      `DFC_OFS_STATUS: rd_mux = {16'h0000, div_reg, 4'h0, 1'b0, range_err_reg, done_reg, busy};
      `DFC_OFS_TCKSRE: rd_mux = {16'h0000, t_cksre_reg};
      `DFC_OFS_TCKSRX: rd_mux = {16'h0000, t_cksrx_reg};
      `DFC_OFS_TXP:    rd_mux = {16'h0000, t_xp_reg};
      `DFC_OFS_TMOD:   rd_mux = {16'h0000, t_mod_reg};
      `DFC_OFS_TDLLK:  rd_mux = {16'h0000, t_dllk_reg};
      `DFC_OFS_TAOF:   rd_mux = {16'h0000, t_aof_reg};
      default:         rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // sequencer
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_done ? 16'h0000 : cnt_reg - 16'h0001;
    cmd_next  = dfc_pkg::DFC_CMD_NOP;
    cke_next  = link.cke;
    odt_next  = link.odt;
    div_next  = div_reg;
    done_next = 1'b0;
    unique case (st_reg)
      CS_IDLE: begin
        odt_next = odt_idle_reg; // RULE8
        if (go) begin
          odt_next = 1'b0; // RULE7
          if (route_pd_reg) begin
            // same path for fast and slow exit power-down
            st_next  = CS_ODT_OFF; // RULE6
            cnt_next = t_aof_reg; // RULE16
          end else begin
            st_next  = CS_ENTER;
            cmd_next = dfc_pkg::DFC_CMD_SRE;
            cke_next = 1'b0;
            cnt_next = t_cksre_reg; // RULE3 RULE4
          end
        end
      end
      CS_ODT_OFF: begin
        if (cnt_done) begin
          st_next  = CS_ENTER;
          cmd_next = dfc_pkg::DFC_CMD_PDE;
          cke_next = 1'b0;
          cnt_next = t_cksre_reg; // RULE9
        end
      end
      CS_ENTER: begin
        if (cnt_done) begin
          // divider moves only here, with cke and odt low
          st_next  = CS_CHANGE;
          div_next = new_div_reg; // RULE1 RULE10
          cnt_next = t_cksrx_reg; // RULE11
        end
      end
      CS_CHANGE: begin
        // device sees the new rate only at its ticks: stable wait starts after two
        if (chg_tick_reg != 2'h2)
          cnt_next = t_cksrx_reg; // RULE3 RULE11
        else if (cnt_done) begin
          st_next  = CS_EXIT;
          cmd_next = route_pd_reg ? dfc_pkg::DFC_CMD_PDX : dfc_pkg::DFC_CMD_SRX; // RULE3 RULE11
          cke_next = 1'b1;
          cnt_next = t_xp_reg; // RULE4
        end
      end
      CS_EXIT: begin
        if (cnt_done) begin
          st_next  = CS_DLL_RST;
          cmd_next = dfc_pkg::DFC_CMD_MRS_DLL; // RULE12
          cnt_next = t_mod_reg;
        end
      end
      CS_DLL_RST: begin
        if (cnt_done) begin
          if (upd_mr_reg) begin
            st_next  = CS_MR_UPD;
            cmd_next = dfc_pkg::DFC_CMD_MRS_UPD; // RULE13
            cnt_next = t_mod_reg;
          end else begin
            st_next  = CS_RELOCK;
            cnt_next = t_dllk_reg; // RULE17
          end
        end
      end
      CS_MR_UPD: begin
        if (cnt_done) begin
          st_next  = CS_RELOCK;
          cnt_next = t_dllk_reg; // RULE17
        end
      end
      CS_RELOCK: begin
        // cke stays high and odt low until the lock wait ends
        cke_next = 1'b1; // RULE14
        odt_next = 1'b0; // RULE14
        if (cnt_done) begin
          st_next   = CS_IDLE;
          done_next = 1'b1; // RULE18
        end
      end
      default: st_next = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg          <= CS_IDLE;
      cnt_reg         <= 16'h0000;
      div_reg         <= `DFC_DIV_RST;
      div_cnt_reg     <= 8'h00;
      chg_tick_reg    <= 2'h0;
      link.ck_tick    <= 1'b0;
      link.cke        <= 1'b1;
      link.odt        <= 1'b0;
      link.cmd        <= dfc_pkg::DFC_CMD_NOP;
      link.mr_rtt_nom <= 1'b0;
    end else begin
      st_reg          <= st_next; // RULE18
      cnt_reg         <= cnt_next;
      div_reg         <= div_next; // RULE2
      if (st_reg != CS_CHANGE)
        chg_tick_reg <= 2'h0;
      else if (link.ck_tick & (chg_tick_reg != 2'h2))
        chg_tick_reg <= chg_tick_reg + 2'h1;
      link.cke        <= cke_next;
      link.odt        <= odt_next;
      link.cmd        <= cmd_next;
      link.mr_rtt_nom <= rtt_nom_reg;
      // memory clock edge every div_reg+1 system cycles
      if (div_cnt_reg >= div_reg) begin
        div_cnt_reg  <= 8'h00;
        link.ck_tick <= 1'b1;
      end else begin
        div_cnt_reg  <= div_cnt_reg + 8'h01;
        link.ck_tick <= 1'b0;
      end
    end
  end

  // register file
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 12'h000;
      hrdata_o      <= 32'h0000_0000;
      hreadyout_o   <= 1'b1;
      hresp_o       <= 1'b0;
      route_pd_reg  <= 1'b0;
      upd_mr_reg    <= 1'b0;
      rtt_nom_reg   <= 1'b0;
      odt_idle_reg  <= 1'b0;
      new_div_reg   <= `DFC_DIV_RST;
      start_reg     <= 1'b0;
      done_reg      <= 1'b0;
      range_err_reg <= 1'b0;
      t_cksre_reg   <= 16'(`DFC_CKSRE_CYC);
      t_cksrx_reg   <= 16'(`DFC_CKSRX_CYC);
      t_xp_reg      <= 16'(`DFC_XP_CYC);
      t_mod_reg     <= 16'(`DFC_MOD_CYC);
      t_dllk_reg    <= 16'(`DFC_DLLK_CYC);
      t_aof_reg     <= 16'(`DFC_AOF_CYC);
    end else begin
      wr_pend_reg <= addr_ph & hwrite_i;
      if (addr_ph)
        wr_addr_reg <= {haddr_i[11:2], 2'b00};
      if (addr_ph & ~hwrite_i)
        hrdata_o <= rd_mux({haddr_i[11:2], 2'b00});
      start_reg <= wr_ctrl & hwdata_i[`DFC_CTRL_START];
      if (wr_ctrl & ~busy) begin
        route_pd_reg <= hwdata_i[`DFC_CTRL_ROUTE_PD];
        upd_mr_reg   <= hwdata_i[`DFC_CTRL_UPD_MR];
        rtt_nom_reg  <= hwdata_i[`DFC_CTRL_RTT_NOM];
        odt_idle_reg <= hwdata_i[`DFC_CTRL_ODT_IDLE];
        new_div_reg  <= wdiv;
      end
      // set wins over a write-one clear in the same cycle
      if (done_next)
        done_reg <= 1'b1;
      else if (wr_stat & hwdata_i[`DFC_STAT_DONE])
        done_reg <= 1'b0;
      if (start_reg & ~in_range)
        range_err_reg <= 1'b1; // RULE5
      else if (wr_stat & hwdata_i[`DFC_STAT_RANGE_ERR])
        range_err_reg <= 1'b0;
      if (wr_now & ~busy) begin
        if (wr_addr_reg == `DFC_OFS_TCKSRE) t_cksre_reg <= hwdata_i[15:0];
        if (wr_addr_reg == `DFC_OFS_TCKSRX) t_cksrx_reg <= hwdata_i[15:0];
        if (wr_addr_reg == `DFC_OFS_TXP)    t_xp_reg    <= hwdata_i[15:0];
        if (wr_addr_reg == `DFC_OFS_TMOD)   t_mod_reg   <= hwdata_i[15:0];
        if (wr_addr_reg == `DFC_OFS_TDLLK)  t_dllk_reg  <= hwdata_i[15:0];
        if (wr_addr_reg == `DFC_OFS_TAOF)   t_aof_reg   <= hwdata_i[15:0];
      end
    end
  end

  logic unused_ok;
  assign unused_ok = ^{haddr_i[31:12], haddr_i[1:0], hsize_i, htrans_i[0], hwdata_i[31:16]};
endmodule
`default_nettype wire

//--- src/dfc_defs.svh
// constants for the clock frequency change sequencer and its memory-side model
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH

`define DFC_CLK_PERIOD_PS  32'd4000
// register byte offsets
`define DFC_OFS_CTRL       12'h000
`define DFC_OFS_STATUS     12'h004
`define DFC_OFS_TCKSRE     12'h008
`define DFC_OFS_TCKSRX     12'h00C
`define DFC_OFS_TXP        12'h010
`define DFC_OFS_TMOD       12'h014
`define DFC_OFS_TDLLK      12'h018
`define DFC_OFS_TAOF       12'h01C
// control fields
`define DFC_CTRL_START     0
`define DFC_CTRL_ROUTE_PD  1
`define DFC_CTRL_UPD_MR    2
`define DFC_CTRL_RTT_NOM   3
`define DFC_CTRL_ODT_IDLE  4
`define DFC_CTRL_DIV_LSB   8
// status fields
`define DFC_STAT_BUSY      0
`define DFC_STAT_DONE      1
`define DFC_STAT_RANGE_ERR 2
`define DFC_STAT_DIV_LSB   8
// timings in ns and derived cycle counts (least times round up)
`define DFC_T_CKSRE_NS     32'd10
`define DFC_T_CKSRX_NS     32'd10
`define DFC_T_XP_NS        32'd24
`define DFC_T_MOD_NS       32'd60
`define DFC_T_DLLK_NS      32'd2048
`define DFC_T_AOF_NS       32'd10
`define DFC_CYC(ns)        (((ns) * 32'd1000 + `DFC_CLK_PERIOD_PS - 32'd1) / `DFC_CLK_PERIOD_PS)
`define DFC_CKSRE_CYC      `DFC_CYC(`DFC_T_CKSRE_NS)
`define DFC_CKSRX_CYC      `DFC_CYC(`DFC_T_CKSRX_NS)
`define DFC_XP_CYC         `DFC_CYC(`DFC_T_XP_NS)
`define DFC_MOD_CYC        `DFC_CYC(`DFC_T_MOD_NS)
`define DFC_DLLK_CYC       `DFC_CYC(`DFC_T_DLLK_NS)
`define DFC_AOF_CYC        `DFC_CYC(`DFC_T_AOF_NS)
// reset value and divisor limits
`define DFC_DIV_RST        8'h03
`define DFC_DIV_MIN        8'h01
`define DFC_DIV_MAX        8'h0F

`endif

//--- src/dfc_dram.sv
// memory-side end: tracks power state, clock stability and dll lock
`timescale 1ns/10ps
`default_nettype none
`include "dfc_defs.svh"
module dfc_dram #(
  parameter int T_CKSRE_CYC = `DFC_CKSRE_CYC,
  parameter int T_CKSRX_CYC = `DFC_CKSRX_CYC,
  parameter int T_DLLK_CYC  = `DFC_DLLK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  dfc_link_if.dram  link,
  output logic      ready_o,
  output logic      dll_locked_o,
  output logic      rtt_on_o,
  output logic      out_hiz_o,
  output logic      seq_err_o
);
  typedef enum logic [1:0] {DV_IDLE, DV_SR, DV_PD, DV_RELOCK} dfc_dv_type;
  dfc_dv_type  st_reg, st_next;
  logic [15:0] per_cnt_reg, last_per_reg, stable_reg, sleep_reg, lock_reg;
  logic        per_valid_reg, tick_seen_reg, locked_reg, rtt_nom_reg;
  logic        locked_next, rtt_nom_next;
  logic [15:0] lock_next;
  wire         per_change = link.ck_tick & per_valid_reg & (per_cnt_reg != last_per_reg);
  wire         asleep     = (st_reg == DV_SR) | (st_reg == DV_PD);
  wire         clk_dont_care = asleep & (sleep_reg >= 16'(T_CKSRE_CYC)); // RULE3
  wire         is_exit    = (link.cmd == dfc_pkg::DFC_CMD_SRX) | (link.cmd == dfc_pkg::DFC_CMD_PDX);
  wire         early_exit = asleep & is_exit & (stable_reg < 16'(T_CKSRX_CYC)); // RULE3
  wire         relock_bad = (st_reg == DV_RELOCK) & (~link.cke | link.odt);
  wire         err_evt    = (per_change & ~clk_dont_care) | early_exit | relock_bad;

  always_comb begin
    st_next      = st_reg;
    locked_next  = locked_reg;
    rtt_nom_next = rtt_nom_reg;
    lock_next    = (lock_reg == 16'h0000) ? 16'h0000 : lock_reg - 16'h0001;
    if (per_change)
      locked_next = 1'b0;
    unique case (st_reg)
      DV_IDLE: begin
        if (link.cmd == dfc_pkg::DFC_CMD_SRE)
          st_next = DV_SR;
        else if (link.cmd == dfc_pkg::DFC_CMD_PDE)
          st_next = DV_PD;
        else if (link.cmd == dfc_pkg::DFC_CMD_MRS_DLL) begin
          st_next     = DV_RELOCK;
          lock_next   = 16'(T_DLLK_CYC);
          locked_next = 1'b0;
        end
      end
      DV_SR:   if (link.cmd == dfc_pkg::DFC_CMD_SRX) st_next = DV_IDLE;
      DV_PD:   if (link.cmd == dfc_pkg::DFC_CMD_PDX) st_next = DV_IDLE;
      DV_RELOCK: begin
        if (lock_reg == 16'h0000) begin
          st_next     = DV_IDLE;
          locked_next = 1'b1; // RULE15
        end
      end
    endcase
    if (link.cmd == dfc_pkg::DFC_CMD_MRS_UPD)
      rtt_nom_next = link.mr_rtt_nom;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg        <= DV_IDLE;
      per_cnt_reg   <= 16'h0000;
      last_per_reg  <= 16'h0000;
      per_valid_reg <= 1'b0;
      tick_seen_reg <= 1'b0;
      stable_reg    <= 16'h0000;
      sleep_reg     <= 16'h0000;
      lock_reg      <= 16'h0000;
      locked_reg    <= 1'b1;
      rtt_nom_reg   <= 1'b0;
    end else begin
      st_reg      <= st_next;
      lock_reg    <= lock_next;
      locked_reg  <= locked_next;
      rtt_nom_reg <= rtt_nom_next;
      // period measured in system cycles between clock ticks
      if (link.ck_tick) begin
        per_cnt_reg   <= 16'h0000;
        last_per_reg  <= per_cnt_reg;
        // interval up to the first tick after reset is partial, never compared
        per_valid_reg <= tick_seen_reg;
        tick_seen_reg <= 1'b1;
      end else if (per_cnt_reg != 16'hFFFF) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
      if (per_change)
        stable_reg <= 16'h0000;
      else if (stable_reg != 16'hFFFF)
        stable_reg <= stable_reg + 16'h0001;
      if (link.cke)
        sleep_reg <= 16'h0000;
      else if (sleep_reg != 16'hFFFF)
        sleep_reg <= sleep_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o      <= 1'b0;
      dll_locked_o <= 1'b0;
      rtt_on_o     <= 1'b0;
      out_hiz_o    <= 1'b1;
      seq_err_o    <= 1'b0;
    end else begin
      ready_o      <= (st_next == DV_IDLE) & locked_next & link.cke; // RULE15
      dll_locked_o <= locked_next;
      // termination only with nominal setting enabled and awake
      rtt_on_o     <= rtt_nom_next & link.odt & (st_next == DV_IDLE); // RULE8
      out_hiz_o    <= (st_next != DV_IDLE); // RULE16
      if (err_evt)
        seq_err_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- src/dfc_link_if.sv
// link between controller and memory-side model
`timescale 1ns/10ps
`default_nettype none
interface dfc_link_if;
  logic                 ck_tick;
  logic                 cke;
  logic                 odt;
  dfc_pkg::dfc_cmd_type cmd;
  logic                 mr_rtt_nom;
  modport ctrl (output ck_tick, output cke, output odt, output cmd, output mr_rtt_nom);
  modport dram (input ck_tick, input cke, input odt, input cmd, input mr_rtt_nom);
endinterface
`default_nettype wire

//--- src/dfc_pkg.sv
// types shared by both ends of the frequency change link
package dfc_pkg;
  typedef enum logic [2:0] {
    DFC_CMD_NOP,
    DFC_CMD_SRE,
    DFC_CMD_SRX,
    DFC_CMD_PDE,
    DFC_CMD_PDX,
    DFC_CMD_MRS_DLL,
    DFC_CMD_MRS_UPD
  } dfc_cmd_type;
endpackage

//--- verification/ddr3_clock_frequency_change_test.sv
// self-checking bench: controller and memory end joined, plus a faulty driver
`timescale 1ns/10ps
`default_nettype none
`include "dfc_defs.svh"
module ddr3_clock_frequency_change_test;
  localparam logic [11:0] OFS [6]  = '{`DFC_OFS_TCKSRE, `DFC_OFS_TCKSRX, `DFC_OFS_TXP,
                                       `DFC_OFS_TMOD, `DFC_OFS_TDLLK, `DFC_OFS_TAOF};
  localparam logic [15:0] DFLT [6] = '{16'h0003, 16'h0003, 16'h0006, 16'h000F, 16'h0200, 16'h0003};
  localparam logic [15:0] PROG [6] = '{16'h0002, 16'h0002, 16'h0001, 16'h0002, 16'h0004, 16'h0001};
  logic                 clk_i, rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0]          haddr_i, hwdata_i, hrdata_o;
  logic [1:0]           htrans_i;
  logic [2:0]           hsize_i;
  logic                 f_ready, f_locked, f_rtt, f_hiz;
  logic                 ready_o, dll_locked_o, rtt_on_o, out_hiz_o, seq_err_o, seq_err2_o;
  logic [7:0]           cur_div;
  logic                 last_rtt;
  int                   mismatches, compares, gap_cnt, last_gap, bad_cnt, bad_per;
  dfc_pkg::dfc_cmd_type cmd_q [$];
  dfc_pkg::dfc_cmd_type exp_q [$];
  dfc_link_if link_if ();
  dfc_link_if bad_if ();

  dfc_ctrl dfc_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .link(link_if));
  dfc_dram #(.T_CKSRE_CYC(1), .T_CKSRX_CYC(1), .T_DLLK_CYC(2)) dfc_dram_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .link(link_if), .ready_o(ready_o), .dll_locked_o(dll_locked_o),
    .rtt_on_o(rtt_on_o), .out_hiz_o(out_hiz_o), .seq_err_o(seq_err_o));
  dfc_dram #(.T_CKSRE_CYC(1), .T_CKSRX_CYC(1), .T_DLLK_CYC(2)) dfc_dram_fault_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .link(bad_if), .ready_o(f_ready), .dll_locked_o(f_locked),
    .rtt_on_o(f_rtt), .out_hiz_o(f_hiz),
    .seq_err_o(seq_err2_o));
  dfc_chk dfc_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ck_tick(link_if.ck_tick),
    .cke(link_if.cke), .odt(link_if.odt), .cmd(link_if.cmd), .mr_rtt_nom(link_if.mr_rtt_nom));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (rstn_i && link_if.cmd !== dfc_pkg::DFC_CMD_NOP) cmd_q.push_back(link_if.cmd);
    gap_cnt++;
    if (link_if.ck_tick === 1'b1) begin
      last_gap = gap_cnt;
      gap_cnt = 0;
    end
  end

  // faulty far side: ticks every 4 cycles, the controller's reset rate, until its period is changed with cke high
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bad_cnt <= 0;
      bad_if.ck_tick <= 1'b0;
    end else begin
      bad_cnt <= (bad_cnt >= bad_per - 1) ? 0 : bad_cnt + 1;
      bad_if.ck_tick <= (bad_cnt == bad_per - 2);
    end
  end

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 64);
    if (hreadyout_o !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
  endtask

  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= w;
    hsize_i  <= 3'h2;
    htrans_i <= 2'h2;
    wait_rdy;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy;
    rd = hrdata_o;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask

  task rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0000_0000, r);
    check(name, exp, r);
  endtask

  // bounded poll of one status bit; a hang ends the run
  task poll(input int b, output logic [31:0] r);
    int n;
    n = 0;
    do begin
      ahb({20'h0_0000, `DFC_OFS_STATUS}, 1'b0, 32'h0000_0000, r);
      n++;
    end while (r[b] !== 1'b1 && n < 400);
    if (r[b] !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  div;
    logic        pd, upd, rtt, idle;
    int          seed;
    {hsel_i, hwrite_i, htrans_i, hsize_i, haddr_i, hwdata_i} = '0;
    {bad_if.cke, bad_if.odt, bad_if.mr_rtt_nom} = 3'b100;
    bad_if.cmd = dfc_pkg::DFC_CMD_NOP;
    bad_per = 4;
    rstn_i = 1'b0;
    seed = $urandom(37);
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd_chk("status_rst", {20'h0_0000, `DFC_OFS_STATUS}, {16'h0000, `DFC_DIV_RST, 8'h00});
    for (int i = 0; i < 6; i++) begin
      rd_chk("timer_rst", {20'h0_0000, OFS[i]}, {16'h0000, DFLT[i]});
      wr({20'h0_0000, OFS[i]}, {16'h0000, PROG[i]});
      rd_chk("timer_prog", {20'h0_0000, OFS[i]}, {16'h0000, PROG[i]});
    end
    wr(32'h0000_0020, 32'hFFFF_FFFF);
    rd_chk("unmapped", 32'h0000_0020, 32'h0000_0000);
    check("ready_rst", 32'h1, {31'h0, ready_o});
    $display("test registers done");
    cur_div = `DFC_DIV_RST;
    last_rtt = 1'b0;
    // every route, update and termination combination, random divisor
    for (int i = 0; i < 8; i++) begin
      {rtt, upd, pd} = i[2:0];
      idle = 1'($urandom % 2);
      div = 8'($urandom % 15 + 1);
      cmd_q.delete();
      wr({20'h0_0000, `DFC_OFS_CTRL}, {16'h0000, div, 3'h0, idle, rtt, upd, pd, 1'b1});
      ahb({20'h0_0000, `DFC_OFS_STATUS}, 1'b0, 32'h0000_0000, r);
      wr({20'h0_0000, `DFC_OFS_CTRL}, {16'h0000, 8'h0F, 6'h00, ~pd, 1'b1});
      poll(1, r);
      cur_div = div;
      if (upd) last_rtt = rtt;
      check("status_done", {16'h0000, cur_div, 8'h02}, r);
      exp_q = {pd ? dfc_pkg::DFC_CMD_PDE : dfc_pkg::DFC_CMD_SRE,
               pd ? dfc_pkg::DFC_CMD_PDX : dfc_pkg::DFC_CMD_SRX, dfc_pkg::DFC_CMD_MRS_DLL};
      if (upd) exp_q.push_back(dfc_pkg::DFC_CMD_MRS_UPD);
      check("cmd_count", exp_q.size(), cmd_q.size());
      for (int k = 0; k < exp_q.size() && k < cmd_q.size(); k++)
        check("cmd_order", exp_q[k], cmd_q[k]);
      repeat (40) @(posedge clk_i);
      check("tick_gap", cur_div + 1, last_gap);
      check("dram_state", 32'h6, {29'h0, ready_o, dll_locked_o, out_hiz_o});
      check("seq_err", 32'h0, {31'h0, seq_err_o});
      check("odt_idle", {31'h0, idle}, {31'h0, link_if.odt});
      check("rtt_on", {31'h0, last_rtt & idle}, {31'h0, rtt_on_o});
      if (upd) check("mr_rtt", {31'h0, rtt}, {31'h0, link_if.mr_rtt_nom});
      wr({20'h0_0000, `DFC_OFS_STATUS}, 32'h0000_0002);
      rd_chk("done_clr", {20'h0_0000, `DFC_OFS_STATUS}, {16'h0000, cur_div, 8'h00});
    end
    $display("test sequences done");
    // divisors just outside the speed grade limits
    for (int k = 0; k < 2; k++) begin
      cmd_q.delete();
      wr({20'h0_0000, `DFC_OFS_CTRL}, {16'h0000, k ? 8'h10 : 8'h00, 8'h01});
      poll(2, r);
      check("range_err", {16'h0000, cur_div, 8'h04}, r);
      check("range_quiet", 32'h0, cmd_q.size());
      wr({20'h0_0000, `DFC_OFS_STATUS}, 32'h0000_0004);
    end
    $display("test range done");
    check("fault_quiet", 32'h0, {31'h0, seq_err2_o});
    check("fault_idle", 32'hC, {28'h0, f_ready, f_locked, f_rtt, f_hiz});
    bad_per = 2;
    repeat (20) @(posedge clk_i);
    check("fault_seen", 32'h1, {31'h0, seq_err2_o});
    check("fault_unlock", 32'h0, {28'h0, f_ready, f_locked, f_rtt, f_hiz});
    $display("test fault done");
    tally_and_finish;
  end
endmodule
`default_nettype wire

//--- verification/dfc_chk.sv
// concurrent checks on the controller-to-memory link
`timescale 1ns/10ps
`default_nettype none
module dfc_chk (
  input wire logic                 clk_i,
  input wire logic                 rstn_i,
  input wire logic                 ck_tick,
  input wire logic                 cke,
  input wire logic                 odt,
  input wire dfc_pkg::dfc_cmd_type cmd,
  input wire logic                 mr_rtt_nom
);
  logic [7:0] gap_reg;
  logic [7:0] last_gap_reg;
  logic [1:0] hi_ticks_reg;
  wire        entry_w = (cmd == dfc_pkg::DFC_CMD_SRE) || (cmd == dfc_pkg::DFC_CMD_PDE);
  wire        exit_w  = (cmd == dfc_pkg::DFC_CMD_SRX) || (cmd == dfc_pkg::DFC_CMD_PDX);
  wire        mrs_w   = (cmd == dfc_pkg::DFC_CMD_MRS_DLL) || (cmd == dfc_pkg::DFC_CMD_MRS_UPD);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // compare periods only when three prior ticks fell in one cke-high span
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_reg      <= 8'h00;
      last_gap_reg <= 8'h00;
      hi_ticks_reg <= 2'h0;
    end else begin
      gap_reg <= ck_tick ? 8'h01 : gap_reg + 8'h01;
      if (ck_tick) last_gap_reg <= gap_reg;
      if (!cke) hi_ticks_reg <= 2'h0;
      else if (ck_tick && hi_ticks_reg != 2'h3) hi_ticks_reg <= hi_ticks_reg + 2'h1;
    end
  end

  chk_entry_levels: assert property (entry_w |-> !cke && !odt)
    else $error("entry command without cke and odt low");
  chk_pde_after_odt: assert property (cmd == dfc_pkg::DFC_CMD_PDE |-> !$past(odt))
    else $error("power-down entered before odt was low");
  chk_cke_fall_entry: assert property ($fell(cke) |-> entry_w)
    else $error("cke fell without an entry command");
  chk_entry_hold: assert property (entry_w |=> (!cke && !odt) [*2])
    else $error("cke or odt moved too soon after entry");
  chk_exit_levels: assert property (exit_w |-> cke && !odt)
    else $error("exit command without cke high and odt low");
  chk_exit_dll_reset: assert property (exit_w |-> ##[1:64] cmd == dfc_pkg::DFC_CMD_MRS_DLL)
    else $error("no dll reset after exit");
  chk_mrs_levels: assert property (mrs_w |-> cke && !odt)
    else $error("mode register command without cke high");
  chk_relock_hold: assert property (cmd == dfc_pkg::DFC_CMD_MRS_DLL |=> (cke && !odt) [*6])
    else $error("cke or odt moved during relock");
  chk_odt_off_low: assert property (!cke |-> !odt)
    else $error("odt high while cke low");
  chk_period_fixed: assert property (ck_tick && hi_ticks_reg == 2'h3 |-> gap_reg == last_gap_reg)
    else $error("clock period changed while cke high");

  cov_sr_entry: cover property (cmd == dfc_pkg::DFC_CMD_SRE);
  cov_pd_entry: cover property (cmd == dfc_pkg::DFC_CMD_PDE);
  cov_upd_rtt: cover property (cmd == dfc_pkg::DFC_CMD_MRS_UPD && mr_rtt_nom);
  cov_odt_idle: cover property (cke && odt);
endmodule
`default_nettype wire
